// ---- hdl/sleep_ctrl.sv ----
// Sleep mode controller with clock domain gating and Avalon register slave.
//
// Function
// RULE1: Sleep only when enable bit is set.
// RULE2: Halt core four cycles after clock start.
// RULE3: Mode 01 stops CPU, flash, I/O clocks.
// RULE4: Noise reduction keeps ADC, irqs, timers, watchdog.
// RULE5: Noise reduction entry starts enabled conversion.
// RULE6: Noise reduction wake sources limited list.
// RULE7: Mode 10 power-down stops external oscillator.
// RULE8: Power-down wake sources limited list.
// RULE9: Power-down halts all generated clocks.
// RULE10: External level wake must be held.
// RULE11: Deep wake waits fuse-selected time-out.
// RULE12: Mode 11 power-save keeps async timer.
// RULE13: Timer 0 wakes power-save when enabled.
// RULE14: Synchronous timer 0 undefined after power-save.
// RULE15: Power-save stops all but async clock.
// RULE16: Reduction bit stops peripheral clock, blocks access; an asynchronous timer 0 keeps its clock.
// RULE17: Clearing reduction bit resumes frozen state.
// RULE18: Peripheral gating acts in active and idle.
// RULE19: Converter stays enabled; re-enable means extended.
// RULE20: Deep modes disable analog comparator.
// RULE21: Reference on while any user needs it.
// RULE22: Input buffers off when I/O, ADC stopped.
// RULE23: Fused brown-out detector active in sleep.
// RULE24: Enabled watchdog runs in all modes.
// RULE25: Debug enable keeps main clock running.
// RULE26: Mode latched at sleep until wake.
`timescale 1ns/1ps
`default_nettype none
module sleep_ctrl
#(
    parameter int N_PERIPH = sleep_pkg::PR_W,
    parameter int N_PINS = sleep_pkg::PIN_W,
    parameter int TOUT_SHORT = sleep_pkg::TOUT_SHORT_CYC,
    parameter int TOUT_LONG = sleep_pkg::TOUT_LONG_CYC
)
(
    input wire logic mclk,
    input wire logic arst_n,
    // Avalon-MM slave.
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Core side.
    input wire logic sleep_instr,
    input wire logic global_irq_en,
    output logic core_halt,
    // Wake sources, on the same clock.
    input wire sleep_pkg::wake_src_t wake_src,
    input wire logic timer0_async_select,
    input wire logic [1:0] timer0_irq_mask,
    // Configuration levels.
    input wire logic clock_source_fuses,
    input wire logic debug_enable_fuse,
    input wire logic brownout_fuse_en,
    input wire logic adc_enable,
    input wire logic acomp_enable,
    input wire logic acomp_uses_ref,
    input wire logic wdt_enable,
    input wire logic [N_PINS-1:0] wake_pin_mask,
    // Clock domain and analog controls.
    output sleep_pkg::clk_en_t clk_en,
    output logic [N_PERIPH-1:0] periph_clk_en,
    output logic [N_PERIPH-1:0] periph_access_ok,
    output logic adc_auto_start,
    output logic adc_extended_next,
    output logic acomp_active,
    output logic vref_on,
    output logic brownout_active,
    output logic wdt_active,
    output logic [N_PINS-1:0] input_buf_en
);
    localparam logic [sleep_pkg::CNT_W-1:0] HALT_CNT =
        sleep_pkg::CNT_W'(sleep_pkg::WAKE_HALT_CYCLES - 1);
    localparam logic [sleep_pkg::CNT_W-1:0] TS_CNT = sleep_pkg::CNT_W'(TOUT_SHORT - 1);
    localparam logic [sleep_pkg::CNT_W-1:0] TL_CNT = sleep_pkg::CNT_W'(TOUT_LONG - 1);

    // ****************************************************************
    // Registers.
    // ****************************************************************
    sleep_pkg::sleep_state_t state_reg, state_next;
    logic sleep_enable_bit_reg;
    logic [1:0] sleep_mode_select_reg;
    logic [1:0] mode_reg;
    logic [N_PERIPH-1:0] power_reduction_reg;
    logic [N_PINS-1:0] input_disable_reg;
    logic [sleep_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic adc_en_d_reg;
    logic adc_ext_reg;
    logic [31:0] rdata_reg;
    logic rvalid_reg;

    wire logic wake;
    wire logic enter;
    wire logic deep;
    wire logic io_on;
    wire logic sel_ctrl, sel_pr, sel_stat, sel_idis;
    wire logic [31:0] rdata_mux;

    // ****************************************************************
    // Sleep state machine.
    // ****************************************************************
    assign enter = (state_reg == sleep_pkg::ST_ACTIVE) & sleep_instr
        & sleep_enable_bit_reg; // [RULE1]
    assign deep = (mode_reg == sleep_pkg::MODE_PWR_DOWN)
        | (mode_reg == sleep_pkg::MODE_PWR_SAVE);

    wake_filter u_wake
    (
        .mode(mode_reg),
        .src(wake_src),
        .timer0_async_select(timer0_async_select),
        .timer0_irq_mask(timer0_irq_mask),
        .global_irq_en(global_irq_en),
        .wake(wake)
    );

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            sleep_pkg::ST_ACTIVE:
            begin
                // Idle mode is kept outside this block; it never enters here.
                if (enter && sleep_mode_select_reg != sleep_pkg::MODE_IDLE)
                begin
                    state_next = sleep_pkg::ST_SLEEP;
                end
            end
            sleep_pkg::ST_SLEEP:
            begin
                if (wake && deep)
                begin
                    state_next = sleep_pkg::ST_RESTART; // [RULE11]
                    cnt_next = clock_source_fuses ? TL_CNT : TS_CNT;
                end
                else if (wake)
                begin
                    state_next = sleep_pkg::ST_HALT; // [RULE2]
                    cnt_next = HALT_CNT;
                end
            end
            sleep_pkg::ST_RESTART:
            begin
                if (cnt_reg == '0)
                begin
                    state_next = sleep_pkg::ST_HALT; // [RULE2]
                    cnt_next = HALT_CNT;
                end
                else
                begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            sleep_pkg::ST_HALT:
            begin
                if (cnt_reg == '0)
                begin
                    state_next = sleep_pkg::ST_ACTIVE;
                end
                else
                begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= sleep_pkg::ST_ACTIVE;
            cnt_reg <= '0;
            mode_reg <= sleep_pkg::MODE_IDLE;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            if (enter)
            begin
                mode_reg <= sleep_mode_select_reg; // [RULE26]
            end
        end
    end

    // ****************************************************************
    // Clock domains.
    // ****************************************************************
    wire logic asleep = (state_reg == sleep_pkg::ST_SLEEP);
    wire logic restarting = (state_reg == sleep_pkg::ST_RESTART);
    wire logic in_nr = asleep & (mode_reg == sleep_pkg::MODE_ADC_NR);
    wire logic in_deep = (asleep | restarting) & deep;

    assign core_halt = (state_reg != sleep_pkg::ST_ACTIVE);
    assign io_on = ~core_halt | (state_reg == sleep_pkg::ST_HALT);
    // Core and flash stay stopped through the restart and the four halt cycles.
    assign clk_en.cpu = ~core_halt; // [RULE3]
    assign clk_en.flash = ~core_halt; // [RULE3]
    assign clk_en.io = io_on & ~in_nr; // [RULE3] [RULE9] [RULE15]
    assign clk_en.adc = ~in_deep; // [RULE4] [RULE9]
    // Asynchronous timer domain lives on in power-save only among deep modes.
    assign clk_en.asy = ~in_deep | (mode_reg == sleep_pkg::MODE_PWR_SAVE); // [RULE12] [RULE15]
    // Oscillator is stopped until the restart delay begins.
    assign clk_en.main_osc = ~(asleep & deep) | debug_enable_fuse; // [RULE7] [RULE25]

    // Timer 0 keeps its own clock only where the asynchronous domain lives.
    wire logic t0_own_clk = timer0_async_select & clk_en.asy; // [RULE12] [RULE9]

    periph_gate #(.N(N_PERIPH)) u_gate
    (
        .power_reduction_reg(power_reduction_reg),
        .io_clk_on(clk_en.io),
        .timer0_async_select(t0_own_clk),
        .periph_clk_en(periph_clk_en),
        .periph_access_ok(periph_access_ok)
    );

    // ****************************************************************
    // Analog and always-on helpers.
    // ****************************************************************
    assign adc_auto_start = enter & adc_enable
        & (sleep_mode_select_reg == sleep_pkg::MODE_ADC_NR); // [RULE5]
    assign acomp_active = acomp_enable & ~in_deep; // [RULE20]
    assign vref_on = brownout_fuse_en | adc_enable | (acomp_enable & acomp_uses_ref); // [RULE21]
    assign brownout_active = brownout_fuse_en; // [RULE23]
    assign wdt_active = wdt_enable; // [RULE24] [RULE4]
    assign adc_extended_next = adc_ext_reg;
    // Wake pins keep their buffers so level and pin change detection still works.
    assign input_buf_en = ~input_disable_reg
        & (in_deep ? wake_pin_mask : {N_PINS{1'b1}}); // [RULE22]

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            adc_en_d_reg <= 1'b0;
            adc_ext_reg <= 1'b1;
        end
        else
        begin
            adc_en_d_reg <= adc_enable;
            if (adc_enable && !adc_en_d_reg)
            begin
                adc_ext_reg <= 1'b1; // [RULE19]
            end
            else if (adc_auto_start)
            begin
                adc_ext_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Avalon slave: one wait cycle on reads, writes complete at once.
    // ****************************************************************
    assign sel_ctrl = (avs_address == sleep_pkg::ADDR_SLEEP_CTRL);
    assign sel_pr = (avs_address == sleep_pkg::ADDR_POWER_RED);
    assign sel_stat = (avs_address == sleep_pkg::ADDR_STATUS);
    assign sel_idis = (avs_address == sleep_pkg::ADDR_INPUT_DIS);
    assign avs_waitrequest = avs_read & ~rvalid_reg;
    assign avs_readdata = rdata_reg;
    assign rdata_mux = sel_ctrl ? {29'h0, sleep_mode_select_reg, sleep_enable_bit_reg}
        : sel_pr ? {{(32 - N_PERIPH){1'b0}}, power_reduction_reg}
        : sel_stat ? {26'h0, periph_access_ok[0], adc_ext_reg, mode_reg, state_reg}
        : sel_idis ? {{(32 - N_PINS){1'b0}}, input_disable_reg}
        : sleep_pkg::UNMAPPED_DATA;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sleep_enable_bit_reg <= 1'b0;
            sleep_mode_select_reg <= sleep_pkg::MODE_IDLE;
            power_reduction_reg <= '0;
            input_disable_reg <= '0;
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= avs_read & ~rvalid_reg;
            if (avs_read && !rvalid_reg)
            begin
                rdata_reg <= rdata_mux;
            end
            if (avs_write && avs_byteenable[0] && sel_ctrl)
            begin
                sleep_enable_bit_reg <= avs_writedata[sleep_pkg::SE_BIT];
                sleep_mode_select_reg <= avs_writedata[sleep_pkg::SM_LSB +: sleep_pkg::SM_W];
            end
            if (avs_write && avs_byteenable[0] && sel_pr)
            begin
                power_reduction_reg <= avs_writedata[N_PERIPH-1:0]; // [RULE16] [RULE17]
            end
            if (avs_write && sel_idis)
            begin
                if (avs_byteenable[0])
                begin
                    input_disable_reg[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1])
                begin
                    input_disable_reg[15:8] <= avs_writedata[15:8];
                end
            end
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    sequence s_wake_shallow;
        (state_reg == sleep_pkg::ST_SLEEP) && wake && !deep;
    endsequence

    a_enable_gates_sleep: assert property (@(posedge mclk) disable iff (!arst_n) // [RULE1]
        (state_reg == sleep_pkg::ST_ACTIVE) && sleep_instr && !sleep_enable_bit_reg
        |=> state_reg == sleep_pkg::ST_ACTIVE)
        else $error("sleep entered with enable clear");
    a_halt_four_cycles: assert property (@(posedge mclk) disable iff (!arst_n) // [RULE2]
        s_wake_shallow |=> core_halt [*4] ##1 !core_halt)
        else $error("wake halt not four cycles");
    a_nr_clocks: assert property (@(posedge mclk) disable iff (!arst_n) // [RULE3]
        in_nr |-> !clk_en.cpu && !clk_en.io && clk_en.adc && clk_en.asy)
        else $error("noise reduction clocks wrong");
    a_auto_conv: assert property (@(posedge mclk) disable iff (!arst_n) // [RULE5]
        enter && adc_enable && sleep_mode_select_reg == sleep_pkg::MODE_ADC_NR
        |=> in_nr && !adc_ext_reg)
        else $error("no conversion on noise reduction entry");
    a_down_stops: assert property (@(posedge mclk) disable iff (!arst_n) // [RULE9]
        asleep && mode_reg == sleep_pkg::MODE_PWR_DOWN |-> !clk_en.io && !clk_en.adc && !clk_en.asy)
        else $error("power-down clock running");
    a_restart_delay: assert property (@(posedge mclk) disable iff (!arst_n) // [RULE11]
        asleep && deep && wake |=> restarting [*8])
        else $error("restart delay too short");
    a_save_asy: assert property (@(posedge mclk) disable iff (!arst_n) // [RULE15]
        asleep && mode_reg == sleep_pkg::MODE_PWR_SAVE |-> clk_en.asy && !clk_en.io)
        else $error("power-save clocks wrong");
    a_mode_held: assert property (@(posedge mclk) disable iff (!arst_n) // [RULE26]
        asleep && $past(asleep) |-> $stable(mode_reg))
        else $error("mode changed during sleep");
    a_comp_off: assert property (@(posedge mclk) disable iff (!arst_n) // [RULE20]
        in_deep |-> !acomp_active)
        else $error("comparator on in deep sleep");
endmodule : sleep_ctrl
`default_nettype wire

// ---- hdl/sleep_pkg.sv ----
// Package of constants, types and register map for the sleep and clock gating controller.
package sleep_pkg;

    // ****************************************************************
    // Register map, word aligned byte addresses on the Avalon bus.
    // ****************************************************************
    localparam logic [3:0] ADDR_SLEEP_CTRL = 4'h0;
    localparam logic [3:0] ADDR_POWER_RED = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_INPUT_DIS = 4'hC;

    // Field positions of the sleep control register, then the power reduction and input pin widths.
    localparam int SE_BIT = 0;
    localparam int SM_LSB = 1;
    localparam int SM_W = 2;
    localparam int PR_W = 6;
    localparam int PIN_W = 16;

    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // ****************************************************************
    // Sleep mode codes and the controller state.
    // ****************************************************************
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_ADC_NR = 2'h1;
    localparam logic [1:0] MODE_PWR_DOWN = 2'h2;
    localparam logic [1:0] MODE_PWR_SAVE = 2'h3;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP = 2'b01,
        ST_RESTART = 2'b11,
        ST_HALT = 2'b10
    } sleep_state_t;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int WAKE_HALT_CYCLES = 4;
    localparam int CLK_MHZ = 250;
    // Reset time-out choices in microseconds, picked by the clock-source fuses.
    localparam int TOUT_SHORT_US = 4;
    localparam int TOUT_LONG_US = 64;
    localparam int TOUT_SHORT_CYC = TOUT_SHORT_US * CLK_MHZ;
    localparam int TOUT_LONG_CYC = TOUT_LONG_US * CLK_MHZ;
    localparam int CNT_W = 16;

    // ****************************************************************
    // Carriers.
    // ****************************************************************
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
    } clk_en_t;

    typedef struct packed {
        logic adc_done;
        logic ext_reset;
        logic wdt;
        logic brownout;
        logic start_cond;
        logic timer0_ovf;
        logic timer0_cmp;
        logic mem_ready;
        logic ext_level;
        logic pin_change;
    } wake_src_t;

endpackage : sleep_pkg

// ---- hdl/wake_filter.sv ----
// Wake-up source filter: which sources may end the current sleep mode.
`timescale 1ns/1ps
`default_nettype none
module wake_filter
(
    input wire logic [1:0] mode,
    input wire sleep_pkg::wake_src_t src,
    input wire logic timer0_async_select,
    input wire logic [1:0] timer0_irq_mask,
    input wire logic global_irq_en,
    output logic wake
);
    wire logic common_src;
    wire logic t0_ok;
    wire logic adc_nr_ok;
    wire logic down_ok;
    wire logic save_ok;

    // Sources shared by every deep mode.
    assign common_src = src.ext_reset | src.wdt | src.brownout | src.start_cond
        | src.ext_level | src.pin_change;
    // In power-save, timer 0 only wakes when it runs on its own clock, interrupts are enabled and it is unmasked.
    assign t0_ok = timer0_async_select & global_irq_en
        & ((src.timer0_ovf & timer0_irq_mask[0]) | (src.timer0_cmp & timer0_irq_mask[1]));
    assign adc_nr_ok = common_src | src.adc_done | src.mem_ready
        | src.timer0_ovf | src.timer0_cmp; // [RULE6]
    assign down_ok = common_src; // [RULE8]
    assign save_ok = common_src | t0_ok; // [RULE13]

    assign wake = (mode == sleep_pkg::MODE_ADC_NR) ? adc_nr_ok
        : (mode == sleep_pkg::MODE_PWR_DOWN) ? down_ok
        : (mode == sleep_pkg::MODE_PWR_SAVE) ? save_ok
        : 1'b0;
endmodule : wake_filter
`default_nettype wire

// ---- hdl/periph_gate.sv ----
// Per-peripheral clock gate enables and register access blocking.
`timescale 1ns/1ps
`default_nettype none
module periph_gate
#(
    parameter int N = sleep_pkg::PR_W
)
(
    input wire logic [N-1:0] power_reduction_reg,
    input wire logic io_clk_on,
    input wire logic timer0_async_select,
    output logic [N-1:0] periph_clk_en,
    output logic [N-1:0] periph_access_ok
);
    // Bit 2 is timer 0, which keeps its own clock when asynchronous.
    localparam int T0_IDX = 2;

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_gate
            if (i == T0_IDX)
            begin : g_t0
                // Without its own clock, timer 0 stops with the I/O clock in deep sleep.
                assign periph_clk_en[i] = timer0_async_select
                    | (io_clk_on & ~power_reduction_reg[i]); // [RULE16] [RULE17] [RULE14]
            end
            else
            begin : g_other
                // Gating only matters while the I/O clock runs.
                assign periph_clk_en[i] = io_clk_on & ~power_reduction_reg[i]; // [RULE18]
            end
            assign periph_access_ok[i] = ~power_reduction_reg[i]; // [RULE16]
        end
    endgenerate
endmodule : periph_gate
`default_nettype wire

// ---- dv/core_side.sv ----
// Far-side model of the wake sources that face the sleep controller.
`timescale 1ns/1ps
`default_nettype none
module core_side
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic core_halt,
    input wire sleep_pkg::wake_src_t req,
    output sleep_pkg::wake_src_t wake_src
);
    // A level source holds its level for as long as the core stays halted.
    // A short blip could be missed while the clocks are stopped.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            wake_src <= '0;
        else
            wake_src <= core_halt ? req : '0;
    end
endmodule : core_side
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking testbench of the sleep and clock gating controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 0, arst_n = 0, avs_read = 0, avs_write = 0, sleep_instr = 0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, core_halt, adc_auto_start, adc_extended_next;
    logic gie = 0, t0_async = 1, csf = 0, dbg = 0, bo = 0, adc = 0, ac = 0, ac_ref = 0, wdt = 0;
    logic [1:0] t0_mask = 2'h0;
    logic [15:0] pins = 16'h0, input_buf_en;
    logic acomp_active, vref_on, brownout_active, wdt_active, aut;
    logic [5:0] pclk, pok;
    sleep_pkg::clk_en_t clk_en;
    sleep_pkg::wake_src_t req = '0, wake_src;
    int mismatches = 0, n_compared = 0, cyc = 0, n;
    localparam int TOUT_S = 8;
    localparam int TOUT_L = 16;

    always #2 mclk = ~mclk;

    sleep_ctrl #(.TOUT_SHORT(TOUT_S), .TOUT_LONG(TOUT_L)) uut (.mclk(mclk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sleep_instr(sleep_instr), .global_irq_en(gie),
        .core_halt(core_halt), .wake_src(wake_src), .timer0_async_select(t0_async),
        .timer0_irq_mask(t0_mask), .clock_source_fuses(csf), .debug_enable_fuse(dbg),
        .brownout_fuse_en(bo), .adc_enable(adc), .acomp_enable(ac), .acomp_uses_ref(ac_ref),
        .wdt_enable(wdt), .wake_pin_mask(pins), .clk_en(clk_en), .periph_clk_en(pclk),
        .periph_access_ok(pok), .adc_auto_start(adc_auto_start),
        .adc_extended_next(adc_extended_next), .acomp_active(acomp_active), .vref_on(vref_on),
        .brownout_active(brownout_active), .wdt_active(wdt_active), .input_buf_en(input_buf_en));

    core_side far (.mclk(mclk), .arst_n(arst_n), .core_halt(core_halt), .req(req),
        .wake_src(wake_src));

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // The request is held until the rising edge that samples waitrequest low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic sleep();
        @(posedge mclk);
        sleep_instr <= 1'b1;
        @(negedge mclk);
        aut = adc_auto_start;
        @(posedge mclk);
        sleep_instr <= 1'b0;
        repeat (3) @(negedge mclk);
    endtask : sleep

    // Counts the cycles from raising a wake source until the core runs again.
    task automatic wake(input logic [9:0] s);
        n = 0;
        @(posedge mclk);
        req <= sleep_pkg::wake_src_t'(s);
        @(negedge mclk);
        while (core_halt === 1'b1)
        begin
            n++;
            @(negedge mclk);
        end
        @(posedge mclk);
        req <= '0;
    endtask : wake

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_reset();
        bus(0, sleep_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_0030);
        chk(clk_en, 6'h3F);
        bus(0, 4'h1, 32'h0);
        chk(rd, sleep_pkg::UNMAPPED_DATA);
        bus(1, sleep_pkg::ADDR_SLEEP_CTRL, 32'h2);
        sleep();
        chk(core_halt, 1'b0);
    endtask : t_reset

    task automatic t_noise();
        @(posedge mclk);
        adc <= 1'b1;
        ac <= 1'b1;
        wdt <= 1'b1;
        bus(1, sleep_pkg::ADDR_SLEEP_CTRL, 32'h3);
        sleep();
        chk(aut, 1'b1);
        chk(adc_extended_next, 1'b0);
        chk(clk_en, 6'h07);
        chk(core_halt, 1'b1);
        chk(acomp_active, 1'b1);
        // A mode written while asleep must not change the running mode.
        bus(1, sleep_pkg::ADDR_SLEEP_CTRL, 32'h5);
        bus(0, sleep_pkg::ADDR_STATUS, 32'h0);
        chk(rd[3:0], 4'h5);
        chk(clk_en, 6'h07);
        wake(10'h200);
        // One cycle in the far model and one in sleep come before the halt.
        chk(n, 2 + sleep_pkg::WAKE_HALT_CYCLES);
    endtask : t_noise

    task automatic t_down();
        @(posedge mclk);
        adc <= 1'b0;
        bo <= 1'b1;
        pins <= 16'h00F0;
        gie <= 1'b1;
        t0_mask <= 2'h1;
        sleep();
        chk(clk_en, 6'h00);
        chk(aut, 1'b0);
        chk(pclk, 6'h00);
        chk(acomp_active, 1'b0);
        chk(wdt_active, 1'b1);
        chk(brownout_active, 1'b1);
        chk(vref_on, 1'b1);
        chk(input_buf_en, 16'h00F0);
        @(posedge mclk);
        req <= sleep_pkg::wake_src_t'(10'h010);
        repeat (30) @(negedge mclk);
        chk(core_halt, 1'b1);
        wake(10'h001);
        chk(n, 2 + TOUT_S + sleep_pkg::WAKE_HALT_CYCLES);
    endtask : t_down

    task automatic t_save();
        @(posedge mclk);
        csf <= 1'b1;
        dbg <= 1'b1;
        bus(1, sleep_pkg::ADDR_SLEEP_CTRL, 32'h7);
        sleep();
        chk(clk_en, 6'h03);
        chk(pclk, 6'h04);
        // A compare event with its mask bit clear must not wake the device.
        @(posedge mclk);
        req <= sleep_pkg::wake_src_t'(10'h008);
        repeat (10) @(negedge mclk);
        chk(core_halt, 1'b1);
        wake(10'h010);
        chk(n, 2 + TOUT_L + sleep_pkg::WAKE_HALT_CYCLES);
    endtask : t_save

    task automatic t_gate();
        @(posedge mclk);
        t0_async <= 1'b0;
        bo <= 1'b0;
        bus(1, sleep_pkg::ADDR_POWER_RED, 32'h4);
        @(negedge mclk);
        chk({pclk[2], pok[2], pclk[0], vref_on}, 4'b0010);
        @(posedge mclk);
        ac_ref <= 1'b1;
        bus(1, sleep_pkg::ADDR_POWER_RED, 32'h0);
        @(negedge mclk);
        chk({pclk[2], pok[2], vref_on}, 3'b111);
        @(posedge mclk);
        adc <= 1'b1;
        repeat (2) @(negedge mclk);
        chk(adc_extended_next, 1'b1);
    endtask : t_gate

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
        t_noise();
        t_down();
        t_save();
        t_gate();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
